/* src/unb_uart.sv */
// Nine-bit multiprocessor serial channel: control bytes, baud divider,
// two-entry transmit buffer, transmitter and receiver for all four modes.
// Assumes a synchronous byte register port and serial inputs already
// synchronous to core_clk, which serves as the channel's source clock.
`timescale 1ns/1ns
`default_nettype none
module unb_uart
  import unb_pkg::*;
(
  input  wire logic       core_clk,      // Channel and register clock
  input  wire logic       rst_b,         // Asynchronous reset, active low
  input  wire logic [7:0] reg_addr,      // Register address
  input  wire logic       reg_wr,        // Write strobe, one cycle
  input  wire logic       reg_rd,        // Read strobe, one cycle
  input  wire logic [7:0] reg_wdata,     // Write data
  output logic      [7:0] reg_rdata,     // Read data, one cycle after reg_rd
  output logic            tx_buf_ready,  // Transmit buffer can take a byte
  output logic            serial_tx_pin, // Serial out, or shift clock in shift mode
  input  wire logic       serial_rx_in,  // Receive pin level
  output logic            serial_rx_out, // Receive pin drive in shift mode
  output logic            serial_rx_oe,  // Receive pin driven while high
  output logic            rx_irq,        // Receive interrupt request
  output logic            tx_irq         // Transmit interrupt request
);

  typedef struct packed {
    logic [7:0]       conh;
    logic [7:0]       conl;
    logic [7:0]       baud;
    logic [7:0]       rxbuf;
    logic [7:0]       fifo0;
    logic [7:0]       fifo1;
    logic [1:0]       fcnt;
    logic [7:0]       pre;
    unb_tx_state_type txst;
    logic [10:0]      txsh;
    logic [3:0]       txbit;
    logic [3:0]       txsub;
    unb_rx_state_type rxst;
    logic [7:0]       rxsh;
    logic [3:0]       rxbit;
    logic [3:0]       rxsub;
    logic [7:0]       rdata;
    logic             tx_ready;
    logic             tx_pin;
    logic             rx_out;
    logic             rx_oe;
    logic             rx_irq;
    logic             tx_irq;
  } unb_state_type;

  unb_state_type s_q;
  unb_state_type s_d;

  // Next-state logic for the whole channel
  always_comb begin
    unb_mode_type mode;
    logic         tick;
    logic         nine;
    logic [7:0]   div;
    logic [7:0]   txbyte;
    logic         ninth;
    logic [3:0]   stop_idx;
    logic         pop;
    logic         push;
    mode     = unb_mode_type'(s_q.conh[MODE_HI_BIT:MODE_LO_BIT]);
    nine     = s_q.conh[MODE_HI_BIT];
    tick     = (s_q.pre == 8'h00);
    div      = 8'h00;
    txbyte   = s_q.fifo0;
    ninth    = 1'b0;
    stop_idx = 4'h0;
    pop      = 1'b0;
    push     = 1'b0;
    s_d      = s_q;

    // Prescaler giving sixteen ticks per bit
    div = (mode == MODE_UART9F) ? 8'h00 : s_q.baud;
    s_d.pre = tick ? div : s_q.pre - 8'h01;

    // Register writes; pending bits only clear on a written zero
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL_HIGH: begin
          s_d.conh = {reg_wdata[7:3], s_q.conh[RX_NINTH_BIT], reg_wdata[RX_IRQ_EN_BIT],
                      s_q.conh[RX_PEND_BIT] & reg_wdata[RX_PEND_BIT]};
        end
        ADDR_CTRL_LOW: begin
          s_d.conl = {reg_wdata[7:1], s_q.conl[TX_PEND_BIT] & reg_wdata[TX_PEND_BIT]};
        end
        ADDR_BAUD: begin
          s_d.baud = reg_wdata;
        end
        ADDR_DATA: begin
          push = (s_q.fcnt != TX_BUF_DEPTH);
        end
        default: begin
          push = 1'b0;
        end
      endcase
    end

    // Register reads; data address returns the receive buffer
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL_HIGH: s_d.rdata = s_q.conh;
        ADDR_CTRL_LOW:  s_d.rdata = s_q.conl;
        ADDR_DATA:      s_d.rdata = s_q.rxbuf;
        ADDR_BAUD:      s_d.rdata = s_q.baud;
        default:        s_d.rdata = 8'h00;
      endcase
    end

    // Parity generation overrides the programmed ninth bit
    ninth = s_q.conl[PARITY_GEN_BIT] ? ^txbyte : s_q.conh[TX_NINTH_BIT];
    stop_idx = nine ? IDX_STOP_NINE : IDX_TAIL;

    // Transmitter
    case (s_q.txst)
      TX_IDLE: begin
        s_d.tx_pin = 1'b1;
        if (s_q.fcnt != 2'h0) begin
          if (mode != MODE_SHIFT) begin
            pop = 1'b1;
            s_d.txst  = TX_ASYNC;
            s_d.txsh  = nine ? {1'b1, ninth, txbyte, 1'b0}
                             : {2'b11, txbyte, 1'b0};
            s_d.txbit = 4'h0;
            s_d.txsub = 4'h0;
            s_d.pre   = div;
          end else if (s_q.rxst == RX_IDLE) begin
            pop = 1'b1;
            s_d.txst  = TX_SYNC;
            s_d.txsh  = {3'b111, txbyte};
            s_d.txbit = 4'h0;
            s_d.txsub = 4'h0;
            s_d.pre   = div;
          end
        end
      end
      TX_ASYNC: begin
        s_d.tx_pin = s_q.txsh[0];
        if (tick) begin
          s_d.txsub = s_q.txsub + 4'h1;
          if (s_q.txsub == TICK_LAST) begin
            s_d.txsh  = {1'b1, s_q.txsh[10:1]};
            s_d.txbit = s_q.txbit + 4'h1;
            if (s_q.txbit + 4'h1 == stop_idx) begin
              s_d.conl[TX_PEND_BIT] = 1'b1;
            end
            if (s_q.txbit == stop_idx) begin
              s_d.txst = TX_IDLE;
            end
          end
        end
      end
      TX_SYNC: begin
        // Shift clock low in first half of each bit, data on rx pin
        s_d.tx_pin = (s_q.txsub >= TICK_RISE);
        if (tick) begin
          s_d.txsub = s_q.txsub + 4'h1;
          if (s_q.txsub == TICK_LAST) begin
            s_d.txsh  = {1'b1, s_q.txsh[10:1]};
            s_d.txbit = s_q.txbit + 4'h1;
            if (s_q.txbit + 4'h1 == SYNC_BITS) begin
              s_d.conl[TX_PEND_BIT] = 1'b1;
              s_d.txst = TX_IDLE;
            end
          end
        end
      end
      default: begin
        s_d.txst = TX_IDLE;
      end
    endcase

    // Two-entry transmit buffer; a write while full is dropped
    if (pop) begin
      s_d.fifo0 = s_q.fifo1;
    end
    if (push) begin
      if ((pop ? s_q.fcnt - 2'h1 : s_q.fcnt) == 2'h0) begin
        s_d.fifo0 = reg_wdata;
      end else begin
        s_d.fifo1 = reg_wdata;
      end
    end
    s_d.fcnt = s_q.fcnt + {1'b0, push} - {1'b0, pop};
    s_d.tx_ready = (s_d.fcnt != TX_BUF_DEPTH);

    // Receiver
    case (s_q.rxst)
      RX_IDLE: begin
        if (s_q.conh[RX_ENABLE_BIT]) begin
          if (mode != MODE_SHIFT && !serial_rx_in) begin
            s_d.rxst  = RX_ASYNC;
            s_d.rxbit = 4'h0;
            s_d.rxsub = 4'h0;
          end else if (mode == MODE_SHIFT && !s_q.conh[RX_PEND_BIT]
                       && s_q.txst == TX_IDLE && s_q.fcnt == 2'h0) begin
            s_d.rxst  = RX_SYNC;
            s_d.rxbit = 4'h0;
            s_d.rxsub = 4'h0;
            s_d.pre   = div;
          end
        end
      end
      RX_ASYNC: begin
        if (tick) begin
          s_d.rxsub = s_q.rxsub + 4'h1;
          if (s_q.rxsub == TICK_CENTRE) begin
            if (s_q.rxbit == 4'h0 && serial_rx_in) begin
              s_d.rxst = RX_IDLE; // Glitch, not a real start bit
            end else if (s_q.rxbit != 4'h0 && s_q.rxbit <= IDX_LAST_DATA) begin
              s_d.rxsh = {serial_rx_in, s_q.rxsh[7:1]};
            end else if (s_q.rxbit == IDX_TAIL) begin
              // Ninth bit in nine-bit modes, stop bit in eight-bit mode
              if (nine) begin
                s_d.conh[RX_NINTH_BIT] = serial_rx_in;
              end
              if (!s_q.conh[MP_FILTER_BIT] || serial_rx_in) begin
                s_d.rxbuf = s_q.rxsh;
                s_d.conh[RX_PEND_BIT] = 1'b1;
              end
              s_d.rxst = RX_WAIT;
            end
          end
          if (s_q.rxsub == TICK_LAST) begin
            s_d.rxbit = s_q.rxbit + 4'h1;
          end
        end
      end
      RX_WAIT: begin
        // Rearm only once the line is back at idle level
        if (serial_rx_in) begin
          s_d.rxst = RX_IDLE;
        end
      end
      RX_SYNC: begin
        s_d.tx_pin = (s_q.rxsub >= TICK_RISE);
        if (tick) begin
          s_d.rxsub = s_q.rxsub + 4'h1;
          if (s_q.rxsub == TICK_RISE) begin
            s_d.rxsh = {serial_rx_in, s_q.rxsh[7:1]};
          end
          if (s_q.rxsub == TICK_LAST) begin
            s_d.rxbit = s_q.rxbit + 4'h1;
            if (s_q.rxbit + 4'h1 == SYNC_BITS) begin
              s_d.rxbuf = s_q.rxsh;
              s_d.conh[RX_PEND_BIT] = 1'b1;
              s_d.rxst = RX_IDLE;
            end
          end
        end
      end
      default: begin
        s_d.rxst = RX_IDLE;
      end
    endcase

    // Receive pin is only driven while shifting out in shift mode
    s_d.rx_oe  = (s_d.txst == TX_SYNC);
    s_d.rx_out = s_d.txst == TX_SYNC ? s_d.txsh[0] : 1'b1;

    // Interrupt requests follow pending flags gated by enables
    s_d.rx_irq = s_d.conh[RX_PEND_BIT] & s_d.conh[RX_IRQ_EN_BIT];
    s_d.tx_irq = s_d.conl[TX_PEND_BIT] & s_d.conl[TX_IRQ_EN_BIT];
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.conh     <= CTRL_HIGH_RST;
      s_q.conl     <= CTRL_LOW_RST;
      s_q.baud     <= BAUD_RST;
      s_q.txst     <= TX_IDLE;
      s_q.rxst     <= RX_IDLE;
      s_q.tx_ready <= 1'b1;
      s_q.tx_pin   <= 1'b1;
      s_q.rx_out   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata     = s_q.rdata;
  assign tx_buf_ready  = s_q.tx_ready;
  assign serial_tx_pin = s_q.tx_pin;
  assign serial_rx_out = s_q.rx_out;
  assign serial_rx_oe  = s_q.rx_oe;
  assign rx_irq        = s_q.rx_irq;
  assign tx_irq        = s_q.tx_irq;

endmodule
`default_nettype wire

/* src/unb_pkg.sv */
// Constants for the nine-bit multiprocessor serial channel.
// Assumes a byte-wide register port using the channel's own register addresses.
package unb_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_CTRL_HIGH = 8'hF9;
  localparam logic [7:0] ADDR_CTRL_LOW  = 8'hFA;
  localparam logic [7:0] ADDR_DATA      = 8'hFB;
  localparam logic [7:0] ADDR_BAUD      = 8'hFC;
  // Reset values
  localparam logic [7:0] CTRL_HIGH_RST  = 8'h00;
  localparam logic [7:0] CTRL_LOW_RST   = 8'h00;
  localparam logic [7:0] BAUD_RST       = 8'h00;
  // High control byte fields
  localparam int MODE_HI_BIT    = 7;
  localparam int MODE_LO_BIT    = 6;
  localparam int MP_FILTER_BIT  = 5;
  localparam int RX_ENABLE_BIT  = 4;
  localparam int TX_NINTH_BIT   = 3;
  localparam int RX_NINTH_BIT   = 2;
  localparam int RX_IRQ_EN_BIT  = 1;
  localparam int RX_PEND_BIT    = 0;
  // Low control byte fields
  localparam int PARITY_GEN_BIT = 7;
  localparam int TX_IRQ_EN_BIT  = 1;
  localparam int TX_PEND_BIT    = 0;
  // Oversampling: sixteen ticks per bit, sampled near the centre
  localparam logic [3:0] TICK_LAST   = 4'hF;
  localparam logic [3:0] TICK_CENTRE = 4'h7;
  localparam logic [3:0] TICK_RISE   = 4'h8;
  // Bit indices inside a frame (start bit is index 0)
  localparam logic [3:0] IDX_LAST_DATA  = 4'h8;
  localparam logic [3:0] IDX_TAIL       = 4'h9;
  localparam logic [3:0] IDX_STOP_NINE  = 4'hA;
  localparam logic [3:0] SYNC_BITS      = 4'h8;
  // Transmit buffer depth
  localparam logic [1:0] TX_BUF_DEPTH   = 2'h2;

  typedef enum logic [1:0] {
    MODE_SHIFT   = 2'b00,
    MODE_UART8   = 2'b01,
    MODE_UART9F  = 2'b10,
    MODE_UART9V  = 2'b11
  } unb_mode_type;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SYNC  = 2'b10
  } unb_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_ASYNC = 2'b01,
    RX_SYNC  = 2'b10,
    RX_WAIT  = 2'b11
  } unb_rx_state_type;
endpackage

/* testbench/unb_uart_checker.sv */
// Checker: port-level properties of the serial channel.
// Assumes bind onto unb_uart; mode and divisor mirrored from writes.
`timescale 1ns/1ns
`default_nettype none
module unb_uart_checker
  import unb_pkg::*;
(
  input wire logic       core_clk,      // Clock
  input wire logic       rst_b,         // Reset
  input wire logic [7:0] reg_addr,      // Address
  input wire logic       reg_wr,        // Write
  input wire logic       reg_rd,        // Read
  input wire logic [7:0] reg_wdata,     // Write data
  input wire logic [7:0] reg_rdata,     // Read data
  input wire logic       tx_buf_ready,  // Room
  input wire logic       serial_tx_pin, // Line out
  input wire logic       serial_rx_oe,  // Rx drive
  input wire logic       rx_irq,        // Rx request
  input wire logic       tx_irq         // Tx request
);
  logic [1:0]  mode_q; // Mode last written
  logic [7:0]  div_q;  // Divisor last written
  logic [15:0] run_q;  // Low run of tx pin
  logic [15:0] blen;   // Clocks per bit
  // Mirror config; low run judges the bit rate
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 2'h0;
      div_q  <= 8'h00;
      run_q  <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == ADDR_CTRL_HIGH) mode_q <= reg_wdata[7:6];
      if (reg_wr && reg_addr == ADDR_BAUD) div_q <= reg_wdata;
      run_q <= serial_tx_pin ? 16'h0000 : run_q + 16'h0001;
    end
  end
  // Fixed nine-bit mode ignores the divisor
  assign blen = (mode_q == MODE_UART9F) ? 16'h0010 : ({8'h00, div_q} + 16'h0001) << 4;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_off(a, b); reg_wr && reg_addr == a && !reg_wdata[b]; endsequence
  property p_rie; s_off(ADDR_CTRL_HIGH, RX_IRQ_EN_BIT) |=> ##1 !rx_irq; endproperty
  a_rie: assert property (p_rie) else $error("rx_irq while disabled");
  property p_tie; s_off(ADDR_CTRL_LOW, TX_IRQ_EN_BIT) |=> ##1 !tx_irq; endproperty
  a_tie: assert property (p_tie) else $error("tx_irq while disabled");
  property p_unmap;
    reg_rd && !(reg_addr inside {[ADDR_CTRL_HIGH:ADDR_BAUD]}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_stand; !reg_rd |=> $stable(reg_rdata); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_rst;
    $rose(rst_b) |-> tx_buf_ready && serial_tx_pin && !serial_rx_oe && !rx_irq && !tx_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_oe; mode_q != MODE_SHIFT |=> !serial_rx_oe; endproperty
  a_oe: assert property (p_oe) else $error("rx pin driven in async mode");
  property p_rate; mode_q != MODE_SHIFT && $rose(serial_tx_pin) |-> run_q % blen == 0; endproperty
  a_rate: assert property (p_rate) else $error("bit time wrong");
  property p_sclk; mode_q == MODE_SHIFT && $rose(serial_tx_pin) |-> run_q == blen >> 1; endproperty
  a_sclk: assert property (p_sclk) else $error("shift clock low time wrong");
endmodule
bind unb_uart unb_uart_checker u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .tx_buf_ready(tx_buf_ready), .serial_tx_pin(serial_tx_pin),
  .serial_rx_oe(serial_rx_oe), .rx_irq(rx_irq), .tx_irq(tx_irq));
`default_nettype wire

/* testbench/unb_peer.sv */
// Far-side serial peer: drives frames in, decodes the channel's output.
// Assumes the bench sets clocks per bit and bits per frame before use.
`timescale 1ns/1ns
`default_nettype none
module unb_peer (
  input  wire logic clk,   // Bench clock
  input  wire logic tx_ln, // Channel line out
  input  wire logic sh_d,  // Shift-mode data
  input  wire logic sh_oe, // Shift-mode drive
  output logic      rx_ln  // Line in, idles high
);
  int          blen = 32;       // Clocks per bit
  int          nb   = 0;        // Bits decoded, 0 off
  int          cnt  = 0;        // Frames decoded
  logic [10:0] got  = 11'h7FF;  // Latest frame
  logic [10:0] prev = 11'h7FF;  // Frame before
  logic [7:0]  sh   = 8'h00;    // Shift capture
  initial rx_ln = 1'b1;
  // LSB first, blen clocks a bit, then idle
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) rx_ln = f[i];
      repeat (blen - 1) @(negedge clk);
    end
    @(negedge clk) rx_ln = 1'b1;
  endtask
  // Centre sampling; unused high bits stay 1
  always @(negedge tx_ln) if (nb != 0) begin
    prev = got;
    got = 11'h7FF;
    repeat (blen / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      got[i] = tx_ln;
      if (i < nb - 1) repeat (blen) @(posedge clk);
    end
    cnt++;
  end
  // Shift data settles before the clock rises
  always @(posedge tx_ln) if (sh_oe) sh = {sh_d, sh[7:1]};
endmodule
`default_nettype wire

/* testbench/unb_uart_bench.sv */
// Bench for the serial channel: scenario tasks over registers and line.
// Assumes design, bound checker and peer model compiled first.
`timescale 1ns/1ns
`default_nettype none
module unb_uart_bench import unb_pkg::*;;
  logic       core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
  logic       tx_rdy, tx_pin, rx_out, rx_oe, rx_irq, tx_irq, peer_ln;
  wire        rx_ln = rx_oe ? rx_out : peer_ln; // Shared rx pin
  int         err_count = 0;
  int         check_count = 0;
  always #4 core_clk = ~core_clk;
  unb_uart DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata), .tx_buf_ready(tx_rdy),
    .serial_tx_pin(tx_pin), .serial_rx_in(rx_ln), .serial_rx_out(rx_out),
    .serial_rx_oe(rx_oe), .rx_irq(rx_irq), .tx_irq(tx_irq));
  unb_peer peer (.clk(core_clk), .tx_ln(tx_pin), .sh_d(rx_out), .sh_oe(rx_oe), .rx_ln(peer_ln));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Irq outputs change on the edge that takes a write; wait two more edges anyway
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(11'(rdata), 11'(e));
  endtask
  // Bounded wait: 0 peer frame count, 1 rx_irq, 2 tx_irq
  task automatic wt(input int w, input int c);
    int i;
    for (i = 0; i < 5000; i++) begin
      if (w == 0 ? peer.cnt >= c : ((w == 1 ? rx_irq : tx_irq) === 1'b1)) break;
      @(negedge core_clk);
    end
    if (i == 5000) begin
      err_count++;
      $display("Error %0t: wait timed out", $time);
      test_done();
    end
  endtask
  task automatic t_reset();
    rd(ADDR_CTRL_HIGH, CTRL_HIGH_RST);
    rd(ADDR_CTRL_LOW, CTRL_LOW_RST);
    rd(ADDR_BAUD, BAUD_RST);
    rd(8'hF8, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_tx();
    logic [1:0] m;
    int c;
    wr(ADDR_BAUD, 8'h01);
    wr(ADDR_CTRL_LOW, 8'h02);
    for (int k = 1; k < 4; k++) begin
      m = 2'(k);
      c = peer.cnt;
      peer.blen = (m == MODE_UART9F) ? 16 : 32;
      peer.nb = (m == MODE_UART8) ? 10 : 11;
      wr(ADDR_CTRL_HIGH, {m, 6'h08});
      wr(ADDR_DATA, 8'hA5);
      wr(ADDR_DATA, 8'h3C);
      wr(ADDR_DATA, 8'h96);
      chk(11'(tx_rdy), 11'h000);
      wr(ADDR_DATA, 8'hF0);
      wt(0, c + 3);
      chk(peer.prev, {2'b11, 8'h3C, 1'b0});
      chk(peer.got, {2'b11, 8'h96, 1'b0});
      chk(11'(tx_irq), 11'h001);
      repeat (400) @(negedge core_clk);
      chk(11'(peer.cnt), 11'(c + 3));
    end
    wr(ADDR_CTRL_LOW, 8'h01);
    chk(11'(tx_irq), 11'h000);
    wr(ADDR_CTRL_LOW, 8'h03);
    chk(11'(tx_irq), 11'h001);
    wr(ADDR_CTRL_LOW, 8'h02);
    chk(11'(tx_irq), 11'h000);
    wr(ADDR_CTRL_LOW, 8'h82);
    c = peer.cnt;
    wr(ADDR_DATA, 8'h3C);
    wt(0, c + 1);
    chk(peer.got, {2'b10, 8'h3C, 1'b0});
    $display("transmit test done");
  endtask
  task automatic t_rx9();
    peer.blen = 32;
    // Parity off, so the ninth-bit fields carry meaning
    wr(ADDR_CTRL_LOW, 8'h02);
    wr(ADDR_CTRL_HIGH, 8'hF2);
    peer.send({2'b10, 8'h3C, 1'b0}, 11);
    repeat (40) @(negedge core_clk);
    chk(11'(rx_irq), 11'h000);
    peer.send({2'b11, 8'h5A, 1'b0}, 11);
    wt(1, 0);
    rd(ADDR_DATA, 8'h5A);
    rd(ADDR_CTRL_HIGH, 8'hF7);
    wr(ADDR_CTRL_HIGH, 8'hD2);
    peer.send({2'b10, 8'h77, 1'b0}, 11);
    wt(1, 0);
    rd(ADDR_DATA, 8'h77);
    wr(ADDR_CTRL_HIGH, 8'hD1);
    chk(11'(rx_irq), 11'h000);
    rd(ADDR_CTRL_HIGH, 8'hD1);
    wr(ADDR_CTRL_HIGH, 8'hD0);
    rd(ADDR_CTRL_HIGH, 8'hD0);
    $display("nine-bit receive test done");
  endtask
  task automatic t_rx8();
    wr(ADDR_CTRL_HIGH, 8'h72);
    peer.send({2'b00, 8'hC3, 1'b0}, 10);
    repeat (40) @(negedge core_clk);
    chk(11'(rx_irq), 11'h000);
    peer.send({2'b01, 8'h81, 1'b0}, 10);
    wt(1, 0);
    rd(ADDR_DATA, 8'h81);
    wr(ADDR_CTRL_HIGH, 8'h52);
    peer.send({2'b01, 8'h11, 1'b0}, 10);
    peer.send({2'b01, 8'h22, 1'b0}, 10);
    wt(1, 0);
    rd(ADDR_DATA, 8'h22);
    wr(ADDR_CTRL_HIGH, 8'h42);
    peer.send({2'b01, 8'h44, 1'b0}, 10);
    repeat (40) @(negedge core_clk);
    chk(11'(rx_irq), 11'h000);
    $display("eight-bit receive test done");
  endtask
  task automatic t_shift();
    peer.nb = 0;
    wr(ADDR_CTRL_HIGH, 8'h00);
    wr(ADDR_CTRL_LOW, 8'h02);
    wr(ADDR_DATA, 8'hC5);
    wt(2, 0);
    chk(11'(peer.sh), 11'h0C5);
    wr(ADDR_CTRL_HIGH, 8'h12);
    wt(1, 0);
    // Pending still set: no second shift clock may start
    repeat (8) @(negedge core_clk);
    chk(11'(tx_pin), 11'h001);
    rd(ADDR_DATA, 8'hFF);
    wr(ADDR_CTRL_HIGH, 8'h02);
    $display("shift test done");
  endtask
  initial begin
    // Three rising edges under reset before release
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    t_reset();
    t_tx();
    t_rx9();
    t_rx8();
    t_shift();
    test_done();
  end
endmodule
`default_nettype wire
